/* File: logic/low_power_mode_controller.sv */
// Low-power mode sequencer: mode state, clock gates, peripheral holds and resets, frame-timed wake-up.
// Assumes the CPU pulses the instruction strobes for one cycle and all inputs are synchronous to clk_sys_in.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Standby stops CPU clocks; oscillators, interrupts, timers, serial keep running.
// - Standby holds RAM, registers and I/O pin states unchanged.
// - Standby ends on reset or interrupt, resuming at next instruction.
// - After standby wake, interrupt serviced if global enable set, else pending.
// - Stop instruction with watch select clear enters stop, halting main oscillator.
// - Stop resets CPU, timers, serial, LCD, A/D, I/O; outputs float; RAM kept.
// - After stop, RAM kept; accumulator, pointers, carry, serial data undefined.
// - Watch entered by stop with watch select, or either instruction in subactive.
// - Watch: timer A and LCD run; others stop; CPU, RAM, I/O held. The code keeps the serial enabled in watch, with its interrupt off.
// - Watch exits on reset or timer A/ext0 request; slow flag picks target.
// - Watch to active: settle period after timer A; one to two frames plus settle for ext0.
// - Subactive runs CPU on sub clock, all peripherals except A/D.
// - Direct transfer flag settable only in subactive; cleared on reaching active.
// - Subactive, slow flag 0, direct flag 1: instruction goes active after settle time.
// - In watch and subactive, timer A and ext0 requests align to selectable frame.
// - Requests rise one settle period after an interrupt strobe.
// - Ext0 falling edge counts at the second strobe after the edge.
// - Ext0 sampled once per frame; edge is a high sample then low sample.
// - Instruction coinciding with strobe in subactive cancels timer A and ext0 requests.
// - Global enable clear with unmasked flag set makes instruction a no-operation.
// - Asynchronous reset resets the device from any mode.
module low_power_mode_controller #(
   parameter int SETTLE_CYC = lpm_pkg::OSC_SETTLE_CYC,
   parameter int RAM_AW = 4,
   parameter int RAM_DW = 4
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic standby_instruction_in,
   input wire logic stop_instruction_in,
   input wire logic watch_select_bit_in,
   input wire logic slow_clock_flag_in,
   input wire logic direct_transfer_wr_in,
   input wire logic direct_transfer_val_in,
   input wire logic global_interrupt_enable_in,
   input wire logic unmasked_flag_pending_in,
   input wire logic any_irq_in,
   input wire logic timer_a_overflow_in,
   input wire logic external_interrupt_zero_in,
   input wire logic [1:0] frame_sel_in,
   input wire logic ram_we_in,
   input wire logic [RAM_AW-1:0] ram_addr_in,
   input wire logic [RAM_DW-1:0] ram_wdata_in,
   output logic [RAM_DW-1:0] ram_rdata_out,
   output logic [2:0] mode_out,
   output logic cpu_clk_en_out,
   output logic cpu_on_sub_clk_out,
   output logic main_osc_en_out,
   output logic per_clk_en_out,
   output logic timer_a_en_out,
   output logic timer_bc_en_out,
   output logic serial_en_out,
   output logic serial_irq_en_out,
   output logic lcd_en_out,
   output logic ad_en_out,
   output logic periph_reset_out,
   output logic io_hold_out,
   output logic io_hiz_out,
   output logic regs_invalid_out,
   output logic direct_transfer_flag_out,
   output logic timer_a_request_flag_out,
   output logic ext_zero_request_flag_out,
   output logic wake_service_out,
   output logic instr_nop_out
);
   initial begin
      if (SETTLE_CYC < 1 || SETTLE_CYC >= (1 << lpm_pkg::CNT_W)) begin
         $error("SETTLE_CYC out of range");
      end
   end

   lpm_pkg::mode_t mode_q;
   logic [lpm_pkg::CNT_W-1:0] frame_cnt_q;
   logic strobe;
   logic [lpm_pkg::CNT_W-1:0] settle_cnt_q;
   logic settle_busy_q;
   logic settle_to_active_q;
   logic settle_ta_q;
   logic settle_e0_q;
   logic ext_sample_q;
   logic ext_edge_seen_q;
   logic dt_flag_q;
   logic ta_pend_q;
   logic regs_invalid_q;
   logic lp_instr;
   logic instr_nop;
   logic low_freq;
   logic strobe_cancel;

   // Frame length in cycles for the given selection
   function automatic logic [lpm_pkg::CNT_W-1:0] frame_len(input logic [1:0] sel);
      if (sel == 2'h0) begin
         frame_len = lpm_pkg::CNT_W'(lpm_pkg::FRAME0_CYC);
      end else if (sel == 2'h1) begin
         frame_len = lpm_pkg::CNT_W'(lpm_pkg::FRAME1_CYC);
      end else begin
         frame_len = lpm_pkg::CNT_W'(lpm_pkg::FRAME2_CYC);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Instruction qualification

   assign lp_instr = standby_instruction_in | stop_instruction_in;
   // An unmasked flag with interrupts off would wake at once, so treat as no-op
   assign instr_nop = lp_instr & ~global_interrupt_enable_in & unmasked_flag_pending_in;
   assign instr_nop_out = instr_nop;
   assign low_freq = (mode_q == lpm_pkg::MODE_WATCH) || (mode_q == lpm_pkg::MODE_SUBACTIVE);
   assign strobe_cancel = (mode_q == lpm_pkg::MODE_SUBACTIVE) & lp_instr & strobe;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt frame timebase

   // Free-running frame counter; strobe marks each frame start
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         frame_cnt_q <= '0;
      end else if (frame_cnt_q >= frame_len(frame_sel_in) - 1'b1) begin
         frame_cnt_q <= '0;
      end else begin
         frame_cnt_q <= frame_cnt_q + 1'b1;
      end
   end
   assign strobe = (frame_cnt_q == '0);

   ////////////////////////////////////////////////////////////////////////////
   // External interrupt zero edge detection

   // One sample per frame; a high-then-low pair marks the edge, taken at next strobe
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         ext_sample_q <= 1'h1;
         ext_edge_seen_q <= 1'h0;
      end else if (!low_freq) begin
         ext_sample_q <= 1'h1;
         ext_edge_seen_q <= 1'h0;
      end else if (strobe) begin
         ext_sample_q <= external_interrupt_zero_in;
         // Seen at one strobe, the settle timer starts from it at the following strobe
         ext_edge_seen_q <= ext_sample_q & ~external_interrupt_zero_in;
      end
   end

   // Timer A overflow held until the next strobe, so it lands on the frame
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         ta_pend_q <= 1'h0;
      end else if (!low_freq) begin
         ta_pend_q <= 1'h0;
      end else if (strobe && !settle_busy_q) begin
         // Consumed or cancelled at this strobe; a busy timer keeps it for the next frame
         ta_pend_q <= 1'h0;
      end else if (timer_a_overflow_in) begin
         ta_pend_q <= 1'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Settle timer: one oscillator settle period from a strobe, or from a direct-transfer instruction, to the request or mode change

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         settle_busy_q <= 1'h0;
         settle_cnt_q <= '0;
         settle_to_active_q <= 1'h0;
         settle_ta_q <= 1'h0;
         settle_e0_q <= 1'h0;
      end else if (settle_busy_q) begin
         if (settle_cnt_q == lpm_pkg::CNT_W'(SETTLE_CYC - 1)) begin
            settle_busy_q <= 1'h0;
         end
         settle_cnt_q <= settle_cnt_q + 1'b1;
      end else if (low_freq && strobe && !strobe_cancel &&
                   ((strobe ? timer_a_overflow_in : 1'b0) | ta_pend_q | ext_edge_seen_q)) begin
         settle_busy_q <= 1'h1;
         settle_cnt_q <= '0;
         settle_ta_q <= ta_pend_q | timer_a_overflow_in;
         settle_e0_q <= ext_edge_seen_q;
         settle_to_active_q <= (mode_q == lpm_pkg::MODE_WATCH) & ~slow_clock_flag_in;
      end else if (mode_q == lpm_pkg::MODE_SUBACTIVE && lp_instr && !instr_nop &&
                   !slow_clock_flag_in && dt_flag_q) begin
         // Direct transfer waits the fixed settle time then goes active
         settle_busy_q <= 1'h1;
         settle_cnt_q <= '0;
         settle_ta_q <= 1'h0;
         settle_e0_q <= 1'h0;
         settle_to_active_q <= 1'h1;
      end
   end

   logic settle_done;
   assign settle_done = settle_busy_q && (settle_cnt_q == lpm_pkg::CNT_W'(SETTLE_CYC - 1));

   // Request flags: one-cycle pulses on the edge where the settle timer ends, cleared on every other cycle
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         timer_a_request_flag_out <= lpm_pkg::FLAG_RESET;
         ext_zero_request_flag_out <= lpm_pkg::FLAG_RESET;
      end else if (settle_done) begin
         timer_a_request_flag_out <= settle_ta_q;
         ext_zero_request_flag_out <= settle_e0_q;
      end else begin
         timer_a_request_flag_out <= 1'h0;
         ext_zero_request_flag_out <= 1'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode state machine

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         mode_q <= lpm_pkg::MODE_ACTIVE;
      end else begin
         case (mode_q)
            lpm_pkg::MODE_ACTIVE: begin
               if (standby_instruction_in && !instr_nop) begin
                  mode_q <= lpm_pkg::MODE_STANDBY;
               end else if (stop_instruction_in && !instr_nop) begin
                  mode_q <= watch_select_bit_in ? lpm_pkg::MODE_WATCH : lpm_pkg::MODE_STOP;
               end
            end
            lpm_pkg::MODE_STANDBY: begin
               if (any_irq_in) begin
                  mode_q <= lpm_pkg::MODE_ACTIVE;
               end
            end
            lpm_pkg::MODE_STOP: begin
               mode_q <= lpm_pkg::MODE_STOP;
            end
            lpm_pkg::MODE_WATCH: begin
               if (settle_done) begin
                  mode_q <= settle_to_active_q ? lpm_pkg::MODE_ACTIVE : lpm_pkg::MODE_SUBACTIVE;
               end
            end
            lpm_pkg::MODE_SUBACTIVE: begin
               if (settle_done && settle_to_active_q) begin
                  mode_q <= lpm_pkg::MODE_ACTIVE;
               end else if (lp_instr && !instr_nop && !settle_busy_q && !dt_flag_q) begin
                  mode_q <= lpm_pkg::MODE_WATCH;
               end else if (lp_instr && !instr_nop && slow_clock_flag_in && dt_flag_q) begin
                  mode_q <= lpm_pkg::MODE_WATCH;
               end
            end
            default: begin
               mode_q <= lpm_pkg::MODE_ACTIVE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Direct transfer flag

   // Writable only in subactive; forced clear in active so active reads zero; held in standby, stop and watch
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         dt_flag_q <= lpm_pkg::FLAG_RESET;
      end else if (settle_done && settle_to_active_q) begin
         // Cleared on the edge that enters active, so active never shows it set
         dt_flag_q <= 1'h0;
      end else if (mode_q == lpm_pkg::MODE_SUBACTIVE) begin
         if (direct_transfer_wr_in) begin
            dt_flag_q <= direct_transfer_val_in;
         end
      end else if (mode_q == lpm_pkg::MODE_ACTIVE) begin
         dt_flag_q <= 1'h0;
      end
   end
   assign direct_transfer_flag_out = dt_flag_q;

   // Wake from standby, or from watch into active: service now only if interrupts are enabled
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wake_service_out <= 1'h0;
      end else begin
         wake_service_out <= global_interrupt_enable_in &
            (((mode_q == lpm_pkg::MODE_STANDBY) && any_irq_in) ||
             ((mode_q == lpm_pkg::MODE_WATCH) && settle_done && settle_to_active_q));
      end
   end

   // Core registers lose validity in stop; reset is the only way out
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         regs_invalid_q <= 1'h0;
      end else if (mode_q == lpm_pkg::MODE_STOP) begin
         regs_invalid_q <= 1'h1;
      end
   end
   assign regs_invalid_out = regs_invalid_q | (mode_q == lpm_pkg::MODE_STOP);

   ////////////////////////////////////////////////////////////////////////////
   // Clock gates and peripheral controls per mode

   always_comb begin
      mode_out = mode_q;
      cpu_clk_en_out = (mode_q == lpm_pkg::MODE_ACTIVE) || (mode_q == lpm_pkg::MODE_SUBACTIVE);
      cpu_on_sub_clk_out = (mode_q == lpm_pkg::MODE_SUBACTIVE);
      main_osc_en_out = (mode_q == lpm_pkg::MODE_ACTIVE) || (mode_q == lpm_pkg::MODE_STANDBY);
      per_clk_en_out = main_osc_en_out || (mode_q == lpm_pkg::MODE_SUBACTIVE);
      timer_a_en_out = (mode_q != lpm_pkg::MODE_STOP);
      timer_bc_en_out = per_clk_en_out;
      serial_en_out = per_clk_en_out || (mode_q == lpm_pkg::MODE_WATCH);
      serial_irq_en_out = per_clk_en_out;
      lcd_en_out = (mode_q != lpm_pkg::MODE_STOP);
      ad_en_out = main_osc_en_out;
      periph_reset_out = (mode_q == lpm_pkg::MODE_STOP);
      io_hold_out = (mode_q == lpm_pkg::MODE_STANDBY) || (mode_q == lpm_pkg::MODE_WATCH);
      io_hiz_out = (mode_q == lpm_pkg::MODE_STOP);
   end

   // Data memory has no reset, retained through every mode
   lpm_ram #(
      .AW(RAM_AW),
      .DW(RAM_DW)
   ) u_ram (
      .clk_sys_in(clk_sys_in),
      .we_in(ram_we_in & cpu_clk_en_out),
      .addr_in(ram_addr_in),
      .wdata_in(ram_wdata_in),
      .rdata_out(ram_rdata_out)
   );
endmodule
`default_nettype wire

/* File: logic/lpm_pkg.sv */
// Package for the low-power mode controller: mode encoding, frame choices and timing counts.
// Assumes a 25 MHz system clock; the frame tick and sub-clock are modelled in system clock cycles.
package lpm_pkg;
   // Operating modes
   typedef enum logic [2:0] {
      MODE_ACTIVE,
      MODE_STANDBY,
      MODE_STOP,
      MODE_WATCH,
      MODE_SUBACTIVE
   } mode_t;

   localparam int CLK_PERIOD_NS = 40;
   // Oscillator settle period in ns and its least cycle count
   localparam int OSC_SETTLE_NS = 640;
   localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Interrupt frame lengths in ns for the three selections
   localparam int FRAME0_NS = 1280;
   localparam int FRAME1_NS = 2560;
   localparam int FRAME2_NS = 5120;
   localparam int FRAME0_CYC = FRAME0_NS / CLK_PERIOD_NS;
   localparam int FRAME1_CYC = FRAME1_NS / CLK_PERIOD_NS;
   localparam int FRAME2_CYC = FRAME2_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 16;
   localparam logic [1:0] FRAME_SEL_RESET = 2'h0;
   localparam logic FLAG_RESET = 1'h0;
endpackage

/* File: logic/lpm_ram.sv */
// Small RAM standing for the core data memory that low-power modes must retain.
// Assumes a single clock; read data come out of a register.
`timescale 1ns/10ps
`default_nettype none
module lpm_ram #(
   parameter int AW = 4,
   parameter int DW = 4
) (
   input wire logic clk_sys_in,
   input wire logic we_in,
   input wire logic [AW-1:0] addr_in,
   input wire logic [DW-1:0] wdata_in,
   output logic [DW-1:0] rdata_out
);
   logic [DW-1:0] mem_q [0:(1<<AW)-1];

   // Contents have no reset, so they survive every mode including stop
   always_ff @(posedge clk_sys_in) begin
      if (we_in) begin
         mem_q[addr_in] <= wdata_in;
      end
      rdata_out <= mem_q[addr_in];
   end
endmodule
`default_nettype wire

/* File: sim/lpm_checker_asserts.sv */
// Checker for the low-power controller: per-mode gating and instruction entry.
// Assumes it is bound onto the controller top; one clock, reset async active high.
`timescale 1ns/10ps
`default_nettype none
module lpm_checker (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic standby_instruction_in,
   input wire logic stop_instruction_in,
   input wire logic watch_select_bit_in,
   input wire logic global_interrupt_enable_in,
   input wire logic unmasked_flag_pending_in,
   input wire logic [2:0] mode_out,
   input wire logic cpu_clk_en_out,
   input wire logic cpu_on_sub_clk_out,
   input wire logic main_osc_en_out,
   input wire logic timer_a_en_out,
   input wire logic timer_bc_en_out,
   input wire logic serial_en_out,
   input wire logic serial_irq_en_out,
   input wire logic lcd_en_out,
   input wire logic ad_en_out,
   input wire logic periph_reset_out,
   input wire logic io_hold_out,
   input wire logic io_hiz_out,
   input wire logic direct_transfer_flag_out,
   input wire logic instr_nop_out,
   input wire logic per_clk_en_out
);
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   // An instruction in active mode that was not turned into a no-op
   logic take;
   assign take = mode_out == 3'h0 && !instr_nop_out;
   // Gating per mode
   a_standby_gating: assert property (
      mode_out == 3'h1 |-> !cpu_clk_en_out && main_osc_en_out && timer_a_en_out && serial_en_out && per_clk_en_out)
      else $error("standby gating wrong");
   a_standby_holds: assert property (
      mode_out == 3'h1 |-> io_hold_out && !io_hiz_out && !periph_reset_out)
      else $error("standby hold wrong");
   a_stop_resets: assert property (
      mode_out == 3'h2 |-> periph_reset_out && io_hiz_out && !main_osc_en_out && !cpu_clk_en_out && !per_clk_en_out)
      else $error("stop reset wrong");
   a_watch_units: assert property (
      mode_out == 3'h3 |-> timer_a_en_out && lcd_en_out && !timer_bc_en_out && !ad_en_out && !serial_irq_en_out)
      else $error("watch units wrong");
   a_sub_clocking: assert property (
      mode_out == 3'h4 |-> cpu_clk_en_out && cpu_on_sub_clk_out && !ad_en_out && timer_bc_en_out)
      else $error("subactive units wrong");
   // Stop is left only through reset, so it must persist while reset is low
   a_stop_persists: assert property (
      mode_out == 3'h2 |=> mode_out == 3'h2)
      else $error("stop left without reset");
   a_direct_cleared: assert property (
      mode_out == 3'h0 |-> !direct_transfer_flag_out)
      else $error("direct flag set in active");
   // Entry from active mode
   a_standby_entry: assert property (
      standby_instruction_in && take |=> mode_out == 3'h1)
      else $error("standby not entered");
   a_stop_entry: assert property (
      stop_instruction_in && !watch_select_bit_in && take |=> mode_out == 3'h2)
      else $error("stop not entered");
   a_watch_entry: assert property (
      stop_instruction_in && watch_select_bit_in && take |=> mode_out == 3'h3)
      else $error("watch not entered");
   a_nop_cancel: assert property (
      mode_out == 3'h0 && (standby_instruction_in || stop_instruction_in) && !global_interrupt_enable_in
      && unmasked_flag_pending_in |-> instr_nop_out ##1 mode_out == 3'h0)
      else $error("instruction not cancelled");
   // Main scenarios
   c_watch_wake: cover property (mode_out == 3'h3 ##1 mode_out == 3'h0);
   c_sub_entry: cover property (mode_out == 3'h3 ##1 mode_out == 3'h4);
   c_direct: cover property (mode_out == 3'h4 ##1 mode_out == 3'h0);
endmodule
bind low_power_mode_controller lpm_checker lpm_checker_i (.clk_sys_in, .rst_in, .standby_instruction_in,
   .stop_instruction_in, .watch_select_bit_in, .global_interrupt_enable_in, .unmasked_flag_pending_in,
   .mode_out, .cpu_clk_en_out, .cpu_on_sub_clk_out, .main_osc_en_out, .timer_a_en_out, .timer_bc_en_out,
   .serial_en_out, .serial_irq_en_out, .lcd_en_out, .ad_en_out, .periph_reset_out, .io_hold_out,
   .io_hiz_out, .direct_transfer_flag_out, .instr_nop_out, .per_clk_en_out);
`default_nettype wire

/* File: sim/lpm_ext_source.sv */
// Behavioural source for the external wake-up line of the low-power controller.
// Assumes one system clock; the level only changes after standing for hold_cyc_in cycles.
`timescale 1ns/10ps
`default_nettype none
module lpm_ext_source (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic fire_in,
   input wire logic [15:0] hold_cyc_in,
   output logic ext0_out,
   output logic ready_out
);
   ////////////////////////////////////////////////////////////////
   logic level_q;
   logic [15:0] since_q;
   // High before the fall and low after it, each for the hold time, so a frame sample never misses it
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         level_q <= 1'b1;
         since_q <= 16'h0;
      end else if (since_q >= hold_cyc_in && (fire_in || !level_q)) begin
         level_q <= !level_q;
         since_q <= 16'h0;
      end else if (since_q != 16'hffff) begin
         since_q <= since_q + 16'h1;
      end
   end
   // A request to fall is only honoured once the high level has stood long enough
   assign ext0_out = level_q;
   assign ready_out = level_q && since_q >= hold_cyc_in;
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the low-power controller with an external wake-up source model.
// Assumes the controller package is compiled first; inputs change by NBA at the rising edge.
`timescale 1ns/10ps
`default_nettype none
module tb;
   ////////////////////////////////////////////////////////////////
   localparam int SETTLE = 16;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic sb = 1'b0, st = 1'b0, ws = 1'b0, sl = 1'b0, dw = 1'b0, dv = 1'b0;
   logic ge = 1'b0, up = 1'b0, ai = 1'b0, ta = 1'b0, fire = 1'b0, we = 1'b0;
   logic [1:0] fs = 2'h0;
   logic [3:0] ad = 4'h0, wd = 4'h0, rd;
   logic [2:0] mode;
   logic ext0, ready, rinv, dtf, taf, ezf, wake;
   logic [15:0] rnd = 16'h34fd;
   int mismatches = 0, n_compared = 0, cyc = 0, n_wake = 0, n_ezf = 0, n_taf = 0;
   int ram_m [16];
   low_power_mode_controller #(.SETTLE_CYC(SETTLE)) low_power_mode_controller_i (.clk_sys_in, .rst_in,
      .standby_instruction_in(sb), .stop_instruction_in(st), .watch_select_bit_in(ws), .slow_clock_flag_in(sl),
      .direct_transfer_wr_in(dw), .direct_transfer_val_in(dv), .global_interrupt_enable_in(ge),
      .unmasked_flag_pending_in(up), .any_irq_in(ai), .timer_a_overflow_in(ta), .external_interrupt_zero_in(ext0),
      .frame_sel_in(fs), .ram_we_in(we), .ram_addr_in(ad), .ram_wdata_in(wd), .ram_rdata_out(rd), .mode_out(mode),
      .cpu_clk_en_out(), .cpu_on_sub_clk_out(), .main_osc_en_out(), .per_clk_en_out(), .timer_a_en_out(),
      .timer_bc_en_out(), .serial_en_out(), .serial_irq_en_out(), .lcd_en_out(), .ad_en_out(),
      .periph_reset_out(), .io_hold_out(), .io_hiz_out(), .regs_invalid_out(rinv), .direct_transfer_flag_out(dtf),
      .timer_a_request_flag_out(taf), .ext_zero_request_flag_out(ezf), .wake_service_out(wake), .instr_nop_out());
   lpm_ext_source lpm_ext_source_i (.clk_sys_in, .rst_in, .fire_in(fire), .hold_cyc_in(16'h0100),
      .ext0_out(ext0), .ready_out(ready));
   // Clock at 25 MHz
   initial begin
      forever #20 clk_sys_in = !clk_sys_in;
   end
   // Pulse counters and the hang limit
   always @(posedge clk_sys_in) begin
      cyc++;
      n_wake += (wake === 1'b1);
      n_ezf += (ezf === 1'b1);
      n_taf += (taf === 1'b1);
      if (cyc == 20000) begin
         mismatches++;
         complete_run();
      end
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic check_mode(input int m);
      check("mode", {13'h0, mode}, 16'(m));
   endtask
   task automatic setp(input logic w, input logic s, input logic g, input logic u, input logic a);
      @(posedge clk_sys_in);
      {ws, sl, ge, up, ai} <= {w, s, g, u, a};
   endtask
   // One-cycle instruction strobe; mode is looked at once the taking edge has landed
   task automatic instr(input logic use_stop);
      @(posedge clk_sys_in);
      st <= use_stop;
      sb <= !use_stop;
      @(posedge clk_sys_in);
      st <= 1'b0;
      sb <= 1'b0;
      #1;
   endtask
   task automatic dwr(input logic val);
      @(posedge clk_sys_in);
      dw <= 1'b1;
      dv <= val;
      @(posedge clk_sys_in);
      dw <= 1'b0;
      #1;
   endtask
   task automatic wait_mode(input int m, input int lim);
      for (int i = 0; i < lim && mode !== 3'(m); i++) begin
         @(posedge clk_sys_in);
         #1;
      end
   endtask
   task automatic ram_rd(input logic [3:0] a, output logic [3:0] v);
      @(posedge clk_sys_in);
      ad <= a;
      @(posedge clk_sys_in);
      #1;
      v = rd;
   endtask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // Main sequence; the firmware side clears interrupts before each instruction except the no-op one, which has an unmasked flag pending
   initial begin
      int t0;
      logic [3:0] v;
      repeat (16) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      #1;
      check_mode(0);
      dwr(1'b1);
      check("dtf", {15'h0, dtf}, 16'h0);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         @(posedge clk_sys_in);
         we <= 1'b1;
         ad <= 4'(i);
         wd <= rnd[3:0];
         ram_m[i] = rnd[3:0];
      end
      @(posedge clk_sys_in);
      we <= 1'b0;
      // Standby woken with and without global enable
      for (int g = 1; g >= 0; g--) begin
         setp(1'b0, 1'b0, 1'(g), 1'b0, 1'b0);
         instr(1'b0);
         check_mode(1);
         n_wake = 0;
         setp(1'b0, 1'b0, 1'(g), 1'b0, 1'b1);
         wait_mode(0, 8);
         check_mode(0);
         setp(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
         repeat (2) @(posedge clk_sys_in);
         check("wake", 16'(n_wake), 16'(g));
         ram_rd(4'h1, v);
         check("ram", {12'h0, v}, 16'(ram_m[1]));
      end
      setp(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      instr(1'b1);
      check_mode(0);
      // Stop: interrupts ignored, only reset leaves, RAM kept
      setp(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      instr(1'b1);
      check_mode(2);
      setp(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      repeat (10) @(posedge clk_sys_in);
      #1;
      check_mode(2);
      check("rinv", {15'h0, rinv}, 16'h1);
      rst_in <= 1'b1;
      repeat (SETTLE) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      setp(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      #1;
      check_mode(0);
      ram_rd(4'h2, v);
      check("ram", {12'h0, v}, 16'(ram_m[2]));
      // Watch woken by timer A under every frame length
      for (int f = 0; f < 3; f++) begin
         fs <= 2'(f);
         setp(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
         instr(1'b1);
         check_mode(3);
         rnd = lfsr(rnd);
         n_taf = 0;
         repeat (rnd[3:0]) @(posedge clk_sys_in);
         ta <= 1'b1;
         @(posedge clk_sys_in);
         ta <= 1'b0;
         #1;
         t0 = cyc;
         wait_mode(0, 300);
         check_mode(0);
         check("ta_time", 16'((cyc - t0) >= SETTLE && (cyc - t0) <= (32 << f) + SETTLE + 3), 16'h1);
         // The flag pulse is counted at the edge after it rises
         @(posedge clk_sys_in);
         #1;
         check("taf", 16'(n_taf), 16'h1);
      end
      // Ext0 wakes watch into subactive, then direct transfer back to active
      fs <= 2'h0;
      for (int k = 0; k < 2; k++) begin
         setp(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
         instr(k == 0);
         check_mode(3);
         for (int i = 0; i < 2000 && ready !== 1'b1; i++) @(posedge clk_sys_in);
         n_ezf = 0;
         fire <= 1'b1;
         @(posedge clk_sys_in);
         fire <= 1'b0;
         wait_mode(4, 200);
         check_mode(4);
         @(posedge clk_sys_in);
         #1;
         check("ezf", 16'(n_ezf), 16'h1);
      end
      dwr(1'b1);
      check("dtf", {15'h0, dtf}, 16'h1);
      setp(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      instr(1'b1);
      wait_mode(0, 100);
      check_mode(0);
      check("dtf", {15'h0, dtf}, 16'h0);
      complete_run();
   end
endmodule
`default_nettype wire
